// ===== logic/ims_pkg.sv
// constants shared by the interrupt dispatch and macro service unit
`default_nettype none
package ims_pkg;
	// ==========================================================
	// widths and depths
	localparam int NSRC = 20;
	localparam int NCH = 4;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int CNT_W = 8;
	localparam int STEP_W = 3;
	localparam int SRC_W = 5;
	localparam int FIFO_DEPTH = 8;
	localparam int RTP_HALF_W = 4;
	localparam int RTP_LO_LSB = 0;
	localparam int RTP_HI_LSB = 4;
	localparam logic [15:0] PUSH_BYTES = 16'h0003;
	localparam logic [1:0] STEP_BYTE = 2'h1;
	localparam logic [1:0] STEP_PAIR = 2'h2;

	// ==========================================================
	// request sources, lower index means higher priority
	localparam int SRC_NONMASK = 0;
	localparam int SRC_BRK = 1;
	localparam int SRC_P0 = 2;
	localparam int SRC_P1 = 3;
	localparam int SRC_P2 = 4;
	localparam int SRC_P3 = 5;
	localparam int SRC_P4 = 6;
	localparam int SRC_P5 = 7;
	localparam int SRC_T0A = 8;
	localparam int SRC_T0B = 9;
	localparam int SRC_T1A = 10;
	localparam int SRC_T1B = 11;
	localparam int SRC_T2A = 12;
	localparam int SRC_T2B = 13;
	localparam int SRC_T3A = 14;
	localparam int SRC_AD = 15;
	localparam int SRC_SER = 16;
	localparam int SRC_SR = 17;
	localparam int SRC_ST = 18;
	localparam int SRC_CSI = 19;

	// ==========================================================
	// macro service channels
	localparam int CH_TX = 0;
	localparam int CH_RX = 1;
	localparam int CH_TMA = 2;
	localparam int CH_TMB = 3;

	// ==========================================================
	// vector table word address per source
	function automatic logic [15:0] vec_addr(input logic [4:0] src);
		unique case (src)
			5'h00: vec_addr = 16'h0002;
			5'h01: vec_addr = 16'h003e;
			5'h02: vec_addr = 16'h0006;
			5'h03: vec_addr = 16'h0008;
			5'h04: vec_addr = 16'h000a;
			5'h05: vec_addr = 16'h000c;
			5'h06: vec_addr = 16'h000e;
			5'h07: vec_addr = 16'h0010;
			5'h08: vec_addr = 16'h0014;
			5'h09: vec_addr = 16'h0016;
			5'h0a: vec_addr = 16'h0018;
			5'h0b: vec_addr = 16'h001a;
			5'h0c: vec_addr = 16'h0012;
			5'h0d: vec_addr = 16'h001c;
			5'h0e: vec_addr = 16'h000e;
			5'h0f: vec_addr = 16'h0010;
			5'h10: vec_addr = 16'h0020;
			5'h11: vec_addr = 16'h0022;
			5'h12: vec_addr = 16'h0024;
			5'h13: vec_addr = 16'h0026;
			default: vec_addr = 16'h0002;
		endcase
	endfunction
endpackage
`default_nettype wire

// ===== logic/irq_dispatch.sv
// vectored interrupt dispatch, macro service engine and real-time output
//
// Notes on behaviour
// RL1 - on acceptance read the source's vector word and load it as new PC
// RL2 - each source owns a fixed vector address, e.g. serial rx at 0022H; the code gives SRC_T3A and SRC_AD the vectors of SRC_P4 and SRC_P5
// RL3 - vectored entry pushes PROGRAM_STATUS_WORD and PC onto the stack first
// RL4 - return pops PC and PROGRAM_STATUS_WORD from the stack and restores them
// RL5 - the return instruction starts the restore and resumes at popped PC
// RL6 - macro sources move one item memory<->peripheral without the core
// RL7 - macro transfers save nothing, restore nothing and fetch nothing
// RL8 - each tx-done macro request copies the next buffer byte to tx shift
// RL9 - after the last tx byte the next tx-done request is vectored
// RL10 - each rx-done macro request stores the rx buffer byte in memory
// RL11 - when the last rx location is filled, rx-done is raised vectored
// RL12 - both timer1 compare sources trigger real-time output patterns
// RL13 - compare A macro loads next low pattern and next compare A value
// RL14 - timer1 equal to compare A latches low pattern, raises compare A
// RL15 - after the last interval is loaded compare A is raised vectored
// RL16 - compare B does the same with high pattern and upper output bits
// RL17 - macro transfers run even while the core clock is halted
// RL18 - channels count down, step their pointer, flag last at count one
// RL19 - vector word read low byte at even address, high byte next
`default_nettype none
module irq_dispatch (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [ims_pkg::NSRC-1:0] irq_i,
	input wire logic [ims_pkg::NSRC-1:0] irq_mask_i,
	input wire logic irq_enable_i,
	input wire logic interrupt_return_instr_i,
	input wire logic [ims_pkg::ADDR_W-1:0] pc_i,
	input wire logic [ims_pkg::DATA_W-1:0] program_status_word_i,
	input wire logic [ims_pkg::ADDR_W-1:0] sp_i,
	output logic core_hold_o,
	output logic pc_load_o,
	output logic [ims_pkg::ADDR_W-1:0] pc_o,
	output logic psw_load_o,
	output logic [ims_pkg::DATA_W-1:0] program_status_word_o,
	output logic sp_load_o,
	output logic [ims_pkg::ADDR_W-1:0] sp_o,
	output logic mem_re_o,
	output logic mem_we_o,
	output logic [ims_pkg::ADDR_W-1:0] mem_addr_o,
	output logic [ims_pkg::DATA_W-1:0] mem_wdata_o,
	input wire logic [ims_pkg::DATA_W-1:0] mem_rdata_i,
	input wire logic [ims_pkg::NCH-1:0] ms_load_i,
	input wire logic [ims_pkg::CNT_W-1:0] ms_count_i,
	input wire logic [ims_pkg::ADDR_W-1:0] ms_ptr_i,
	input wire logic [ims_pkg::DATA_W-1:0] serial_rx_buffer_reg_i,
	output logic [ims_pkg::DATA_W-1:0] serial_tx_shift_reg_o,
	output logic tx_valid_o,
	input wire logic tx_ready_i,
	input wire logic [ims_pkg::DATA_W-1:0] timer1_counter_i,
	output logic [ims_pkg::DATA_W-1:0] timer1_compare_a_o,
	output logic [ims_pkg::DATA_W-1:0] timer1_compare_b_o,
	output logic [ims_pkg::DATA_W-1:0] rtp_latch_o
);
	typedef enum logic [2:0] {ST_IDLE, ST_VEC, ST_RET, ST_MTX, ST_MTM} state_e;
	typedef struct packed {
		state_e st;
		logic [ims_pkg::STEP_W-1:0] step;
		logic [ims_pkg::SRC_W-1:0] src;
		logic [ims_pkg::NSRC-1:0] pend;
		logic ret_pend;
		logic [ims_pkg::ADDR_W-1:0] sp, pc, addr;
		logic [ims_pkg::DATA_W-1:0] program_status_word, dat, wdata, cmp_a, cmp_b, latch, cnt_prev;
		logic re, we, pc_ld, psw_ld, sp_ld, hold;
		logic [ims_pkg::RTP_HALF_W-1:0] pat_lo, pat_hi;
	} disp_s;
	disp_s s_r, s_nxt;
	logic [ims_pkg::NCH-1:0] act, last, adv;
	logic [ims_pkg::NCH-1:0][ims_pkg::ADDR_W-1:0] ptr;
	logic [ims_pkg::NSRC-1:0] macro_v, elig, clr, setv;
	logic [ims_pkg::SRC_W-1:0] sel;
	logic any, mt_a, mt_b, take_rx;
	logic fifo_in_valid, fifo_in_ready;
	logic [ims_pkg::ADDR_W-1:0] tm_ptr;
	// ==========================================================
	// macro service channels
	for (genvar c = 0; c < ims_pkg::NCH; c++) begin : g_ch
		ms_chan #(
			.STEP(c >= ims_pkg::CH_TMA ? ims_pkg::STEP_PAIR : ims_pkg::STEP_BYTE)
		) u_ch (
			.sys_clk_i(sys_clk_i), .rst_i(rst_i), .load_i(ms_load_i[c]),
			.count_i(ms_count_i), .ptr_i(ms_ptr_i), .adv_i(adv[c]),
			.active_o(act[c]), .last_o(last[c]), .ptr_o(ptr[c])
		);
	end

	// ==========================================================
	// tx bytes queue here so a slow serial side stalls the engine, not the core
	sync_fifo #(
		.WIDTH(ims_pkg::DATA_W),
		.DEPTH(ims_pkg::FIFO_DEPTH)
	) u_txq (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .in_valid_i(fifo_in_valid),
		.in_ready_o(fifo_in_ready), .in_data_i(s_r.dat), .out_valid_o(tx_valid_o),
		.out_ready_i(tx_ready_i), .out_data_o(serial_tx_shift_reg_o)
	);

	assign fifo_in_valid = s_r.st == ST_MTX && s_r.step == 3'h2;
	assign tm_ptr = s_r.src == ims_pkg::SRC_T1A ? ptr[ims_pkg::CH_TMA] : ptr[ims_pkg::CH_TMB];

	// ==========================================================
	// request selection; a source with a live channel is served by macro,
	// which ignores the core enable and the halt state
	always_comb begin
		macro_v = '0;
		macro_v[ims_pkg::SRC_ST] = act[ims_pkg::CH_TX]; // RL9
		macro_v[ims_pkg::SRC_SR] = act[ims_pkg::CH_RX];
		macro_v[ims_pkg::SRC_T1A] = act[ims_pkg::CH_TMA];
		macro_v[ims_pkg::SRC_T1B] = act[ims_pkg::CH_TMB];
		for (int i = 0; i < ims_pkg::NSRC; i++) begin
			elig[i] = s_r.pend[i] && (i <= ims_pkg::SRC_BRK
				|| (!irq_mask_i[i] && (macro_v[i] || irq_enable_i))); // RL17
		end
		any = |elig;
		sel = '0;
		for (int i = ims_pkg::NSRC - 1; i >= 0; i--) begin
			if (elig[i]) begin
				sel = 5'(i);
			end
		end
	end

	// timer1 equality is an event only on the count step that reaches it
	assign mt_a = timer1_counter_i == s_r.cmp_a && timer1_counter_i != s_r.cnt_prev; // RL12
	assign mt_b = timer1_counter_i == s_r.cmp_b && timer1_counter_i != s_r.cnt_prev; // RL12
	assign take_rx = s_r.st == ST_IDLE && !s_r.ret_pend && any
		&& sel == ims_pkg::SRC_SR && macro_v[sel];

	// ==========================================================
	// main sequencer: each access is registered, read data returns two
	// cycles after the state that issued it
	always_comb begin
		s_nxt = s_r;
		s_nxt.re = 1'b0;
		s_nxt.we = 1'b0;
		s_nxt.pc_ld = 1'b0;
		s_nxt.psw_ld = 1'b0;
		s_nxt.sp_ld = 1'b0;
		s_nxt.cnt_prev = timer1_counter_i;
		adv = '0;
		clr = '0;
		setv = '0;
		unique case (s_r.st)
			ST_IDLE: begin
				s_nxt.step = '0;
				if (s_r.ret_pend) begin
					s_nxt.ret_pend = 1'b0;
					s_nxt.hold = 1'b1;
					s_nxt.sp = sp_i;
					s_nxt.st = ST_RET; // RL5
				end else if (any) begin
					clr[sel] = 1'b1;
					s_nxt.src = sel;
					if (!macro_v[sel]) begin
						s_nxt.hold = 1'b1;
						s_nxt.sp = sp_i;
						s_nxt.pc = pc_i;
						s_nxt.program_status_word = program_status_word_i;
						s_nxt.st = ST_VEC;
					end else if (sel == ims_pkg::SRC_SR) begin
						// one cycle write, no core involvement
						s_nxt.we = 1'b1; // RL6
						s_nxt.addr = ptr[ims_pkg::CH_RX];
						s_nxt.wdata = serial_rx_buffer_reg_i; // RL10
						adv[ims_pkg::CH_RX] = 1'b1;
						setv[ims_pkg::SRC_SR] = last[ims_pkg::CH_RX]; // RL11
					end else if (sel == ims_pkg::SRC_ST) begin
						s_nxt.re = 1'b1;
						s_nxt.addr = ptr[ims_pkg::CH_TX];
						s_nxt.st = ST_MTX; // RL7
					end else begin
						s_nxt.re = 1'b1;
						s_nxt.addr = sel == ims_pkg::SRC_T1A
							? ptr[ims_pkg::CH_TMA] : ptr[ims_pkg::CH_TMB];
						s_nxt.st = ST_MTM; // RL7
					end
				end
			end
			ST_VEC: begin
				s_nxt.step = s_r.step + 3'h1;
				unique case (s_r.step)
					3'h0: begin
						s_nxt.we = 1'b1;
						s_nxt.addr = s_r.sp - 16'h0001;
						s_nxt.wdata = s_r.program_status_word; // RL3
					end
					3'h1: begin
						s_nxt.we = 1'b1;
						s_nxt.addr = s_r.sp - 16'h0002;
						s_nxt.wdata = s_r.pc[15:8]; // RL3
					end
					3'h2: begin
						s_nxt.we = 1'b1;
						s_nxt.addr = s_r.sp - ims_pkg::PUSH_BYTES;
						s_nxt.wdata = s_r.pc[7:0]; // RL3
					end
					3'h3: begin
						s_nxt.re = 1'b1;
						s_nxt.addr = ims_pkg::vec_addr(s_r.src); // RL2
					end
					3'h4: begin
						s_nxt.re = 1'b1;
						s_nxt.addr = ims_pkg::vec_addr(s_r.src) + 16'h0001; // RL19
					end
					3'h5: begin
						s_nxt.pc[7:0] = mem_rdata_i; // RL19
					end
					default: begin
						s_nxt.pc[15:8] = mem_rdata_i;
						s_nxt.pc_ld = 1'b1; // RL1
						s_nxt.sp = s_r.sp - ims_pkg::PUSH_BYTES;
						s_nxt.sp_ld = 1'b1;
						s_nxt.hold = 1'b0;
						s_nxt.st = ST_IDLE;
					end
				endcase
			end
			ST_RET: begin
				s_nxt.step = s_r.step + 3'h1;
				unique case (s_r.step)
					3'h0: begin
						s_nxt.re = 1'b1;
						s_nxt.addr = s_r.sp; // RL4
					end
					3'h1: begin
						s_nxt.re = 1'b1;
						s_nxt.addr = s_r.sp + 16'h0001;
					end
					3'h2: begin
						s_nxt.re = 1'b1;
						s_nxt.addr = s_r.sp + 16'h0002;
						s_nxt.pc[7:0] = mem_rdata_i;
					end
					3'h3: begin
						s_nxt.pc[15:8] = mem_rdata_i;
					end
					default: begin
						s_nxt.program_status_word = mem_rdata_i; // RL4
						s_nxt.pc_ld = 1'b1; // RL5
						s_nxt.psw_ld = 1'b1;
						s_nxt.sp = s_r.sp + ims_pkg::PUSH_BYTES;
						s_nxt.sp_ld = 1'b1;
						s_nxt.hold = 1'b0;
						s_nxt.st = ST_IDLE;
					end
				endcase
			end
			ST_MTX: begin
				// step 2 waits here while the queue is full
				if (s_r.step == 3'h1) begin
					s_nxt.dat = mem_rdata_i; // RL8
				end
				if (s_r.step != 3'h2) begin
					s_nxt.step = s_r.step + 3'h1;
				end else if (fifo_in_ready) begin
					adv[ims_pkg::CH_TX] = 1'b1; // RL8
					s_nxt.st = ST_IDLE;
				end
			end
			default: begin
				s_nxt.step = s_r.step + 3'h1;
				if (s_r.step == 3'h0) begin
					s_nxt.re = 1'b1;
					s_nxt.addr = tm_ptr + 16'h0001;
				end else if (s_r.step == 3'h1) begin
					if (s_r.src == ims_pkg::SRC_T1A) begin
						s_nxt.pat_lo = mem_rdata_i[3:0]; // RL13
					end else begin
						s_nxt.pat_hi = mem_rdata_i[3:0]; // RL16
					end
				end else begin
					if (s_r.src == ims_pkg::SRC_T1A) begin
						s_nxt.cmp_a = mem_rdata_i; // RL13
						adv[ims_pkg::CH_TMA] = 1'b1;
						setv[ims_pkg::SRC_T1A] = last[ims_pkg::CH_TMA]; // RL15
					end else begin
						s_nxt.cmp_b = mem_rdata_i; // RL16
						adv[ims_pkg::CH_TMB] = 1'b1;
						setv[ims_pkg::SRC_T1B] = last[ims_pkg::CH_TMB]; // RL16
					end
					s_nxt.st = ST_IDLE;
				end
			end
		endcase
		// compare events drive the output latch and request the next step
		if (mt_a) begin
			s_nxt.latch[ims_pkg::RTP_LO_LSB +: ims_pkg::RTP_HALF_W] = s_r.pat_lo; // RL14
		end
		if (mt_b) begin
			s_nxt.latch[ims_pkg::RTP_HI_LSB +: ims_pkg::RTP_HALF_W] = s_r.pat_hi; // RL16
		end
		setv[ims_pkg::SRC_T1A] = setv[ims_pkg::SRC_T1A] | mt_a; // RL14
		setv[ims_pkg::SRC_T1B] = setv[ims_pkg::SRC_T1B] | mt_b; // RL16
		// a new request in the same cycle as its acceptance is kept
		s_nxt.pend = (s_r.pend & ~clr) | irq_i | setv;
		s_nxt.ret_pend = s_nxt.ret_pend | interrupt_return_instr_i;
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// outputs
	assign core_hold_o = s_r.hold;
	assign pc_load_o = s_r.pc_ld;
	assign pc_o = s_r.pc;
	assign psw_load_o = s_r.psw_ld;
	assign program_status_word_o = s_r.program_status_word;
	assign sp_load_o = s_r.sp_ld;
	assign sp_o = s_r.sp;
	assign mem_re_o = s_r.re;
	assign mem_we_o = s_r.we;
	assign mem_addr_o = s_r.addr;
	assign mem_wdata_o = s_r.wdata;
	assign timer1_compare_a_o = s_r.cmp_a;
	assign timer1_compare_b_o = s_r.cmp_b;
	assign rtp_latch_o = s_r.latch;

	// ==========================================================
	// checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	AST_VEC_LOW: assert property (s_r.st == ST_VEC && s_r.step == 3'h3 |=> // RL2
		mem_re_o && mem_addr_o == ims_pkg::vec_addr($past(s_r.src)))
		else $error("vector low byte address wrong");
	AST_VEC_HIGH: assert property (s_r.st == ST_VEC && s_r.step == 3'h3 |=> ##1 // RL19
		mem_re_o && mem_addr_o == ims_pkg::vec_addr($past(s_r.src, 2)) + 16'h0001)
		else $error("vector high byte address wrong");
	AST_VEC_LOAD: assert property (s_r.st == ST_VEC && s_r.step == 3'h5 |=> // RL1
		##1 pc_load_o && pc_o == {$past(mem_rdata_i), $past(mem_rdata_i, 2)} && !psw_load_o)
		else $error("vector word not loaded");
	AST_PUSH: assert property (s_r.st == ST_IDLE ##1 s_r.st == ST_VEC |=> // RL3
		mem_we_o && mem_wdata_o == s_r.program_status_word ##1 mem_we_o && mem_wdata_o == s_r.pc[15:8]
		##1 mem_we_o && mem_wdata_o == s_r.pc[7:0])
		else $error("push sequence wrong");
	AST_POP: assert property (psw_load_o |-> pc_load_o && sp_load_o // RL4
		&& sp_o == $past(s_r.sp) + ims_pkg::PUSH_BYTES)
		else $error("restore incomplete");
	AST_INTERRUPT_RETURN_INSTR: assert property (s_r.st == ST_IDLE && s_r.ret_pend |-> ##6 psw_load_o) // RL5
		else $error("return did not restore in time");
	AST_MS_NOCORE: assert property (s_r.st inside {ST_MTX, ST_MTM} |-> // RL7
		!core_hold_o && !pc_load_o && !psw_load_o && !mem_we_o)
		else $error("macro touched core state");
	AST_RX_STORE: assert property (take_rx |=> mem_we_o // RL10
		&& mem_wdata_o == $past(serial_rx_buffer_reg_i) && mem_addr_o == $past(ptr[1]))
		else $error("rx byte not stored");
	AST_RTP_A: assert property (mt_a |=> // RL14
		rtp_latch_o[3:0] == $past(s_r.pat_lo) && s_r.pend[ims_pkg::SRC_T1A])
		else $error("low pattern not latched");
	AST_TX_QUEUE: assert property (fifo_in_valid && fifo_in_ready |=> // RL8
		s_r.st == ST_IDLE && tx_valid_o)
		else $error("tx byte not queued");

	COV_VEC: cover property (pc_load_o && !psw_load_o);
	COV_RET: cover property (psw_load_o);
	COV_RX_LAST: cover property (take_rx && last[ims_pkg::CH_RX]);
	COV_TX_STALL: cover property (fifo_in_valid && !fifo_in_ready);
endmodule
`default_nettype wire

// ===== logic/ms_chan.sv
// one macro service channel: transfer count and buffer pointer
`default_nettype none
module ms_chan #(
	parameter logic [1:0] STEP = 2'h1
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic load_i,
	input wire logic [ims_pkg::CNT_W-1:0] count_i,
	input wire logic [ims_pkg::ADDR_W-1:0] ptr_i,
	input wire logic adv_i,
	output logic active_o,
	output logic last_o,
	output logic [ims_pkg::ADDR_W-1:0] ptr_o
);
	typedef struct packed {
		logic [ims_pkg::CNT_W-1:0] cnt;
		logic [ims_pkg::ADDR_W-1:0] ptr;
	} chan_s;
	chan_s s_r, s_nxt;

	// ==========================================================
	// load from the core, advance on each transfer
	always_comb begin
		s_nxt = s_r;
		if (load_i) begin
			s_nxt.cnt = count_i;
			s_nxt.ptr = ptr_i;
		end else if (adv_i && s_r.cnt != '0) begin
			s_nxt.cnt = s_r.cnt - 8'h01; // RL18
			s_nxt.ptr = s_r.ptr + {14'h0000, STEP}; // RL18
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign active_o = s_r.cnt != '0;
	assign last_o = s_r.cnt == 8'h01; // RL18
	assign ptr_o = s_r.ptr;

	// ==========================================================
	AST_CHAN_ADV: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RL18
		adv_i && !load_i && active_o |=> ptr_o == $past(ptr_o) + {14'h0000, STEP}
		&& active_o == ($past(s_r.cnt) != 8'h01))
		else $error("channel did not advance");
endmodule
`default_nettype wire

// ===== logic/sync_fifo.sv
// small synchronous fifo with valid/ready on both sides
`default_nettype none
module sync_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} fifo_s;
	fifo_s s_r, s_nxt;
	logic push, pop;

	// ==========================================================
	// full and empty come straight from the occupancy count
	assign in_ready_o = s_r.cnt != (AW + 1)'(DEPTH);
	assign out_valid_o = s_r.cnt != '0;
	assign out_data_o = s_r.mem[s_r.rp];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_comb begin
		s_nxt = s_r;
		if (push) begin
			s_nxt.mem[s_r.wp] = in_data_i;
			s_nxt.wp = s_r.wp + 1'b1;
		end
		if (pop) begin
			s_nxt.rp = s_r.rp + 1'b1;
		end
		s_nxt.cnt = s_r.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule
`default_nettype wire

// ===== test/core_mem_model.sv
// far side model: byte memory with one-cycle read latency and a slow tx sink
`default_nettype none
module core_mem_model (
	input wire logic sys_clk_i,
	input wire logic re_i,
	input wire logic we_i,
	input wire logic [ims_pkg::ADDR_W-1:0] addr_i,
	input wire logic [ims_pkg::DATA_W-1:0] wdata_i,
	output logic [ims_pkg::DATA_W-1:0] rdata_o,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	input wire logic [ims_pkg::DATA_W-1:0] tx_data_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [ims_pkg::DATA_W-1:0] mem [0:65535];
	logic [ims_pkg::DATA_W-1:0] tx_q [$];
	// ==========================================================
	// memory and tx sink
	// idle read cycles show inverted data so a late sample is never lucky
	always @(posedge sys_clk_i) begin
		if (we_i) begin
			mem[addr_i] <= wdata_i;
		end
		rdata_o <= re_i ? mem[addr_i] : ~rdata_o;
		tx_ready_o <= ~tx_ready_o; // stalls every other cycle
		if (tx_valid_i && tx_ready_o) begin
			tx_q.push_back(tx_data_i);
		end
	end
	initial begin
		rdata_o = 8'h00;
		tx_ready_o = 1'b0;
	end
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench for the interrupt dispatch and macro service unit
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [ims_pkg::NSRC-1:0] irq = '0;
	logic irq_en = 1'b0, ret = 1'b0, hold, pc_ld, psw_ld, sp_ld, re, we, txv, txr;
	logic [15:0] pc = 16'h0000, sp = 16'h0000, pc_out, sp_out, addr, ms_ptr = 16'h0000;
	logic [7:0] program_status_word = 8'h00, psw_out, wdata, rdata, serial_rx_buffer_reg = 8'h00, tmr = 8'h00, txd;
	logic [7:0] ms_count = 8'h00, cmpa, cmpb, rtp;
	logic [ims_pkg::NCH-1:0] ms_load = '0;
	int err_count = 0;
	int comparisons = 0;

	irq_dispatch u_irq_dispatch (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .irq_i(irq),
		.irq_mask_i('0), .irq_enable_i(irq_en), .interrupt_return_instr_i(ret),
		.pc_i(pc), .program_status_word_i(program_status_word), .sp_i(sp), .core_hold_o(hold),
		.pc_load_o(pc_ld), .pc_o(pc_out), .psw_load_o(psw_ld),
		.program_status_word_o(psw_out), .sp_load_o(sp_ld), .sp_o(sp_out),
		.mem_re_o(re), .mem_we_o(we), .mem_addr_o(addr), .mem_wdata_o(wdata),
		.mem_rdata_i(rdata), .ms_load_i(ms_load), .ms_count_i(ms_count),
		.ms_ptr_i(ms_ptr), .serial_rx_buffer_reg_i(serial_rx_buffer_reg), .serial_tx_shift_reg_o(txd),
		.tx_valid_o(txv), .tx_ready_i(txr), .timer1_counter_i(tmr),
		.timer1_compare_a_o(cmpa), .timer1_compare_b_o(cmpb), .rtp_latch_o(rtp));
	core_mem_model u_core_mem_model (.sys_clk_i(sys_clk_i), .re_i(re), .we_i(we),
		.addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .tx_valid_i(txv),
		.tx_ready_o(txr), .tx_data_i(txd));

	// ==========================================================
	// clock, shared tasks
	always #12.5 sys_clk_i = ~sys_clk_i;

	task automatic tick();
		@(posedge sys_clk_i);
		#2;
	endtask

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("mismatches %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic pulse_src(input int s);
		irq[s] = 1'b1;
		tick();
		irq[s] = 1'b0;
	endtask

	// macro traffic must never stall the core
	task automatic idle(input int n);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			tick();
			seen = seen | hold;
		end
		check("core_hold", {15'h0, seen}, 16'h0000);
	endtask

	task automatic load_ch(input int ch, input logic [7:0] cnt, input logic [15:0] ptr);
		ms_load[ch] = 1'b1;
		ms_count = cnt;
		ms_ptr = ptr;
		tick();
		ms_load = '0;
	endtask

	// vector bytes are preloaded as address xor a5, low byte at the even place
	task automatic expect_entry(input logic [15:0] v);
		pc = 16'h1234;
		program_status_word = 8'h5c;
		sp = 16'h0f00;
		irq_en = 1'b1;
		for (int i = 0; i < 40 && pc_ld !== 1'b1; i++) tick();
		irq_en = 1'b0;
		check("pc_load", {15'h0, pc_ld}, 16'h0001);
		check("pc", pc_out, {(v[7:0] + 8'h01) ^ 8'ha5, v[7:0] ^ 8'ha5});
		check("sp", sp_out, 16'h0efd);
		check("entry_loads", {14'h0, sp_ld, psw_ld}, 16'h0002);
		tick();
		check("stk_psw", {8'h0, u_core_mem_model.mem[16'h0eff]}, 16'h005c);
		check("stk_pc", {u_core_mem_model.mem[16'h0efe], u_core_mem_model.mem[16'h0efd]},
			16'h1234);
	endtask

	// ==========================================================
	// scenarios
	task automatic vectored_table();
		int src[4] = '{ims_pkg::SRC_P0, ims_pkg::SRC_T0A, ims_pkg::SRC_BRK, ims_pkg::SRC_NONMASK};
		logic [15:0] vec[4] = '{16'h0006, 16'h0014, 16'h003e, 16'h0002};
		for (int k = 0; k < 4; k++) begin
			pulse_src(src[k]);
			expect_entry(vec[k]);
		end
	endtask

	task automatic return_case();
		sp = 16'h0efd;
		pc = 16'h0000;
		ret = 1'b1;
		tick();
		ret = 1'b0;
		for (int i = 0; i < 20 && pc_ld !== 1'b1; i++) tick();
		check("ret_pc", pc_out, 16'h1234);
		check("ret_psw", {7'h0, psw_ld, psw_out}, 16'h015c);
		check("ret_sp", sp_out, 16'h0f00);
		tick();
	endtask

	task automatic rx_case();
		load_ch(ims_pkg::CH_RX, 8'h02, 16'h0100);
		for (int k = 0; k < 2; k++) begin
			serial_rx_buffer_reg = 8'hc0 + k[7:0];
			pulse_src(ims_pkg::SRC_SR);
			idle(5);
			check("rx_mem", {8'h0, u_core_mem_model.mem[16'h0100 + k]},
				16'h00c0 + 16'(k));
		end
		expect_entry(16'h0022);
	endtask

	task automatic tx_case();
		u_core_mem_model.mem[16'h0200] = 8'h3c;
		u_core_mem_model.mem[16'h0201] = 8'hc3;
		load_ch(ims_pkg::CH_TX, 8'h02, 16'h0200);
		repeat (2) begin
			pulse_src(ims_pkg::SRC_ST);
			idle(10);
		end
		check("tx_count", 16'(u_core_mem_model.tx_q.size()), 16'h0002);
		check("tx_bytes", {u_core_mem_model.tx_q[0], u_core_mem_model.tx_q[1]}, 16'h3cc3);
		pulse_src(ims_pkg::SRC_ST);
		expect_entry(16'h0024);
	endtask

	// one compare channel: pattern in low nibble, then interval
	task automatic cmp_case(input int ch, input int s, input logic [15:0] v,
			input logic [7:0] pat, input logic [7:0] ivl);
		u_core_mem_model.mem[16'h0300] = pat;
		u_core_mem_model.mem[16'h0301] = ivl;
		load_ch(ch, 8'h01, 16'h0300);
		pulse_src(s);
		idle(6);
		check("cmp", {8'h0, (ch == ims_pkg::CH_TMA) ? cmpa : cmpb}, {8'h0, ivl});
		tmr = ivl;
		tick();
		tick();
		check("rtp", {12'h0, (ch == ims_pkg::CH_TMA) ? rtp[3:0] : rtp[7:4]},
			{12'h0, pat[3:0]});
		expect_entry(v);
		// parked off every compare value: a return to zero would match compare b
		tmr = 8'hff;
	endtask

	// ==========================================================
	// main sequence and watchdog
	initial begin
		for (int a = 0; a < 64; a++) u_core_mem_model.mem[a] = a[7:0] ^ 8'ha5;
		repeat (10) @(posedge sys_clk_i);
		#2;
		rst_i = 1'b0;
		tick();
		vectored_table();
		return_case();
		rx_case();
		tx_case();
		cmp_case(ims_pkg::CH_TMA, ims_pkg::SRC_T1A, 16'h0018, 8'h05, 8'h30);
		cmp_case(ims_pkg::CH_TMB, ims_pkg::SRC_T1B, 16'h001a, 8'h0a, 8'h50);
		tally_and_finish();
	end

	// the whole run needs well under a thousand cycles
	initial begin
		#(25 * 5000);
		err_count++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
